//--- rtl/usil_device.sv
// stepper input logic: programming decode, mapping, chopping selection
// Behaviour
// - all four lines low disables outputs
// - all-low shorter than filter gives no pulse
// - controller raises a line before next bit
// - pulse shifts register up, first to bit0
// - serial bit is XOR of data lines
// - reset clears register, outputs disabled
// - controller programs bit per brief interruption
// - controller programs on a go write, only when idle
// - bit5 selects full or simplified mapping
// - full mapping: low line turns sink on
// - loop line high open, low closed
// - full mapping reduce on pair-high or data
// - full mapping low pair disables stage
// - simplified: phase A, B, enable
// - simplified closed loop reduce on d low
// - open loop on-time from bits 2,3
// - bit4 halves closed loop chop rate
// - nominal reference 0.5V, five levels
// - bits 0,1 pick reduced reference
// - tick sets high side, comparator clears
module usil_device
    import usil_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    usil_link_if.device     link,
    input  wire logic       sense_trip,
    output logic [3:0]      sink_switch_on,
    output logic            high_side_on,
    output logic            current_reduce_flag,
    output logic            open_loop,
    output logic [9:0]      reference_mv,
    output logic [6:0]      on_time_pct,
    output logic [5:0]      cfg_value,
    output logic            shift_strobe
);
    typedef struct packed {
        logic [3:0]  lines_s1;
        logic [3:0]  lines_s2;
        logic        red_s1;
        logic        red_s2;
        logic        loop_s1;
        logic        loop_s2;
        logic [7:0]  low_cnt;
        logic        fired;
        logic [5:0]  cfg;
        logic [11:0] osc_cnt;
        logic        half_div;
        logic [11:0] phase_cnt;
        logic        hs;
        logic [3:0]  sink;
        logic        reduce;
        logic        open;
        logic [9:0]  ref_mv;
        logic [6:0]  ont;
        logic        strobe;
    } usil_dev_s;

    usil_dev_s state_ff;
    usil_dev_s nxt_state;

    logic all_low;
    logic tick;
    logic chop_tick;
    logic stage_off;
    logic red_req;
    logic [9:0] red_mv;
    logic [11:0] on_limit;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.lines_s1 = link.drive_lines;
        nxt_state.lines_s2 = state_ff.lines_s1;
        nxt_state.red_s1   = link.reduce_level_data;
        nxt_state.red_s2   = state_ff.red_s1;
        nxt_state.loop_s1  = link.loop_select_data;
        nxt_state.loop_s2  = state_ff.loop_s1;
        all_low = (state_ff.lines_s2 == 4'h0);

        // filter counter, rearm needs a high line
        nxt_state.strobe = 1'b0;
        if (!all_low) begin
            nxt_state.low_cnt = 8'h00;
            nxt_state.fired   = 1'b0;
        end else if (!state_ff.fired) begin
            if (state_ff.low_cnt + 8'h01 >= FILTER_CNT) begin
                nxt_state.fired  = 1'b1;
                nxt_state.strobe = 1'b1;
                nxt_state.cfg = {state_ff.cfg[4:0], state_ff.red_s2 ^ state_ff.loop_s2};
            end
            nxt_state.low_cnt = state_ff.low_cnt + 8'h01;
        end

        tick = (state_ff.osc_cnt == OSC_CNT - 12'h001);
        nxt_state.osc_cnt = tick ? 12'h000 : state_ff.osc_cnt + 12'h001;
        if (tick) begin
            nxt_state.half_div = ~state_ff.half_div;
        end
        nxt_state.phase_cnt = tick ? 12'h000 : state_ff.phase_cnt + 12'h001;

        nxt_state.open = state_ff.loop_s2;

        case ({state_ff.cfg[CFG_RED1_POS], state_ff.cfg[CFG_RED0_POS]})
            2'b00:   red_mv = REF_40_MV;
            2'b10:   red_mv = REF_55_MV;
            2'b01:   red_mv = REF_70_MV;
            default: red_mv = REF_85_MV;
        endcase

        if (state_ff.cfg[CFG_FULL_POS]) begin
            nxt_state.sink = ~state_ff.lines_s2;
            stage_off = (state_ff.lines_s2[1:0] == 2'b00) || (state_ff.lines_s2[3:2] == 2'b00);
            red_req = (&state_ff.lines_s2[1:0]) || (&state_ff.lines_s2[3:2]) || state_ff.red_s2;
        end else begin
            nxt_state.sink = {state_ff.lines_s2[1], ~state_ff.lines_s2[1],
                              state_ff.lines_s2[0], ~state_ff.lines_s2[0]};
            stage_off = ~state_ff.lines_s2[2];
            red_req = ~state_ff.lines_s2[3] || state_ff.red_s2;
        end
        nxt_state.reduce = red_req && !(state_ff.loop_s2 && !state_ff.cfg[CFG_FULL_POS]);

        nxt_state.ref_mv = red_req ? red_mv : REF_NOM_MV;

        case ({state_ff.cfg[CFG_ONT0_POS], state_ff.cfg[CFG_ONT1_POS]})
            2'b00:   nxt_state.ont = ONT_75;
            2'b01:   nxt_state.ont = ONT_50;
            2'b10:   nxt_state.ont = ONT_100;
            default: nxt_state.ont = ONT_OFF;
        endcase
        on_limit = 12'((32'(state_ff.ont) * OSC_CYC) / 100);

        // high side set on tick, cleared by comparator
        chop_tick = tick && (!state_ff.cfg[CFG_HALF_POS] || state_ff.half_div);
        if (state_ff.loop_s2) begin
            nxt_state.hs = (state_ff.ont != ONT_OFF) && (state_ff.phase_cnt < on_limit);
        end else if (chop_tick) begin
            nxt_state.hs = 1'b1;
        end else if (sense_trip) begin
            nxt_state.hs = 1'b0;
        end

        if (all_low || stage_off) begin
            nxt_state.sink = 4'h0;
            nxt_state.hs   = 1'b0;
        end
    end

    // reset clears register and disables outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign sink_switch_on      = state_ff.sink;
    assign high_side_on        = state_ff.hs;
    assign current_reduce_flag = state_ff.reduce;
    assign open_loop           = state_ff.open;
    assign reference_mv        = state_ff.ref_mv;
    assign on_time_pct         = state_ff.ont;
    assign cfg_value           = state_ff.cfg;
    assign shift_strobe        = state_ff.strobe;
endmodule : usil_device

//--- rtl/usil_pkg.sv
// shared constants and types for the stepper input logic and its controller
package usil_pkg;
    localparam int unsigned CLK_HZ           = 40000000;
    localparam int unsigned CLK_PERIOD_PS    = 25000;
    // all-low protection filter, least time
    localparam int unsigned FILTER_NS        = 200;
    localparam int unsigned FILTER_CYC_RAW   = (FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned FILTER_CYC       = (FILTER_CYC_RAW < 1) ? 1 : FILTER_CYC_RAW;
    localparam logic [7:0]  FILTER_CNT       = 8'(FILTER_CYC);
    // chopping oscillator: one tick per 20 kHz period
    localparam int unsigned OSC_HZ           = 20000;
    localparam int unsigned OSC_CYC          = CLK_HZ / OSC_HZ;
    localparam logic [11:0] OSC_CNT          = 12'(OSC_CYC);
    localparam int unsigned CFG_W            = 6;
    localparam logic [5:0]  CFG_RESET        = 6'h00;
    localparam int unsigned CFG_RED0_POS     = 0;
    localparam int unsigned CFG_RED1_POS     = 1;
    localparam int unsigned CFG_ONT0_POS     = 2;
    localparam int unsigned CFG_ONT1_POS     = 3;
    localparam int unsigned CFG_HALF_POS     = 4;
    localparam int unsigned CFG_FULL_POS     = 5;
    // reference in millivolts: nominal and reduced levels
    localparam logic [9:0]  REF_NOM_MV       = 10'd500;
    localparam logic [9:0]  REF_40_MV        = 10'd200;
    localparam logic [9:0]  REF_55_MV        = 10'd275;
    localparam logic [9:0]  REF_70_MV        = 10'd350;
    localparam logic [9:0]  REF_85_MV        = 10'd425;
    // on-time codes in percent
    localparam logic [6:0]  ONT_75           = 7'd75;
    localparam logic [6:0]  ONT_50           = 7'd50;
    localparam logic [6:0]  ONT_100          = 7'd100;
    localparam logic [6:0]  ONT_OFF          = 7'd0;
    // controller registers on APB
    localparam logic [11:0] REG_CTRL         = 12'h000;
    localparam logic [11:0] REG_DRIVE        = 12'h004;
    localparam logic [11:0] REG_STATUS       = 12'h008;
    localparam int unsigned CTRL_GO_POS      = 0;
    localparam int unsigned CTRL_HOLD_POS    = 1;
    localparam int unsigned CTRL_DATA_LSB    = 8;
    localparam int unsigned DRV_LINES_LSB    = 0;
    localparam int unsigned DRV_RED_POS      = 4;
    localparam int unsigned DRV_LOOP_POS     = 5;
    // controller timing: low hold and high gap between bits
    localparam int unsigned LOW_HOLD_NS      = 2000;
    localparam int unsigned LOW_HOLD_CYC     = (LOW_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0]  LOW_HOLD_CNT     = 8'(LOW_HOLD_CYC);
    localparam int unsigned GAP_NS           = 500;
    localparam int unsigned GAP_CYC          = (GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0]  GAP_CNT          = 8'(GAP_CYC);
    localparam logic [31:0] APB_ZERO         = 32'h0000_0000;

    typedef enum logic [1:0] {USIL_IDLE, USIL_LOW, USIL_HIGH} usil_prog_e;
endpackage : usil_pkg

//--- rtl/usil_link_if.sv
// link between the controller and the stepper input logic
interface usil_link_if;
    logic [3:0] drive_lines;
    logic       reduce_level_data;
    logic       loop_select_data;
    modport device (input drive_lines, input reduce_level_data, input loop_select_data);
    modport ctrl (output drive_lines, output reduce_level_data, output loop_select_data);
endinterface : usil_link_if

//--- rtl/usil_ctrl.sv
// controller end: APB registers drive the lines and program six bits
module usil_ctrl
    import usil_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    usil_link_if.ctrl        link
);
    typedef struct packed {
        logic [3:0]  lines;
        logic        red;
        logic        loop_sel;
        logic [5:0]  data;
        logic        hold;
        logic [2:0]  bit_idx;
        logic [7:0]  cnt;
        usil_prog_e  st;
        logic [3:0]  out_lines;
        logic        out_red;
        logic        out_loop;
        logic [31:0] rdata;
        logic        err;
    } usil_ctrl_s;

    usil_ctrl_s state_ff;
    usil_ctrl_s nxt_state;
    logic       acc;
    logic       busy;
    logic       bitv;

    always_comb begin
        nxt_state = state_ff;
        acc  = psel && penable;
        busy = (state_ff.st != USIL_IDLE);
        nxt_state.err = 1'b0;
        if (psel && !penable) begin
            nxt_state.err = !(paddr == REG_CTRL || paddr == REG_DRIVE || paddr == REG_STATUS);
            case (paddr)
                REG_CTRL:   nxt_state.rdata = {18'h0, state_ff.data, 6'h0, state_ff.hold, busy};
                REG_DRIVE:  nxt_state.rdata = {26'h0, state_ff.loop_sel, state_ff.red, state_ff.lines};
                REG_STATUS: nxt_state.rdata = {27'h0, busy, 1'b0, state_ff.bit_idx};
                default:    nxt_state.rdata = APB_ZERO;
            endcase
        end
        if (acc && pwrite && !state_ff.err) begin
            if (paddr == REG_DRIVE) begin
                nxt_state.lines    = pwdata[DRV_LINES_LSB +: 4];
                nxt_state.red      = pwdata[DRV_RED_POS];
                nxt_state.loop_sel = pwdata[DRV_LOOP_POS];
            end
            // load starts next cycle on a go write, only when idle
            if (paddr == REG_CTRL && !busy && pwdata[CTRL_GO_POS]) begin
                nxt_state.data    = pwdata[CTRL_DATA_LSB +: 6];
                nxt_state.hold    = pwdata[CTRL_HOLD_POS];
                nxt_state.bit_idx = 3'd0;
                nxt_state.cnt     = 8'h00;
                nxt_state.st      = USIL_LOW;
            end
        end
        // bit5 first so it ends in the top position; xor via reduce line
        bitv = state_ff.data[3'd5 - state_ff.bit_idx];
        nxt_state.out_lines = state_ff.lines;
        nxt_state.out_red   = state_ff.red;
        nxt_state.out_loop  = state_ff.loop_sel;
        case (state_ff.st)
            USIL_IDLE: begin
            end
            USIL_LOW: begin
                // data set up with lines low, loop line held at zero
                nxt_state.out_lines = 4'h0;
                nxt_state.out_red   = bitv;
                nxt_state.out_loop  = 1'b0;
                nxt_state.cnt = state_ff.cnt + 8'h01;
                if (state_ff.cnt == LOW_HOLD_CNT) begin
                    nxt_state.cnt = 8'h00;
                    nxt_state.st  = USIL_HIGH;
                end
            end
            USIL_HIGH: begin
                // raise a line between bits; hold keeps stage disabled
                nxt_state.out_lines = state_ff.hold ? 4'h8 : state_ff.lines;
                if (state_ff.lines == 4'h0) begin
                    nxt_state.out_lines = 4'h8;
                end
                nxt_state.cnt = state_ff.cnt + 8'h01;
                if (state_ff.cnt == GAP_CNT) begin
                    nxt_state.cnt = 8'h00;
                    if (state_ff.bit_idx == 3'd5) begin
                        nxt_state.st = USIL_IDLE;
                    end else begin
                        nxt_state.bit_idx = state_ff.bit_idx + 3'd1;
                        nxt_state.st      = USIL_LOW;
                    end
                end
            end
            default: nxt_state.st = USIL_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign prdata                 = state_ff.rdata;
    assign pready                 = 1'b1;
    assign pslverr                = state_ff.err && acc;
    assign link.drive_lines       = state_ff.out_lines;
    assign link.reduce_level_data = state_ff.out_red;
    assign link.loop_select_data  = state_ff.out_loop;
endmodule : usil_ctrl

//--- verif/usil_link_assertions.sv
// concurrent checks on the controller-to-device link and the device outputs
module usil_link_assertions
    import usil_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic [3:0] drive_lines,
    input wire logic       reduce_level_data,
    input wire logic       loop_select_data,
    input wire logic       shift_strobe,
    input wire logic [5:0] cfg_value,
    input wire logic [3:0] sink_switch_on,
    input wire logic       high_side_on,
    input wire logic       open_loop,
    input wire logic       current_reduce_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_RESET_CLEAR: assert property ($rose(presetn) |-> cfg_value == 6'h00)
        else $error("config not cleared by reset");
    AST_STROBE_LOW: assert property (
        shift_strobe |-> $past(drive_lines, 3) == 4'h0 && $past(drive_lines, 9) == 4'h0)
        else $error("shift strobe without a long all-low interval");
    AST_SHIFT: assert property (
        shift_strobe |-> cfg_value ==
            {$past(cfg_value[4:0]), $past(reduce_level_data ^ loop_select_data, 3)})
        else $error("config did not shift in the xor bit");
    AST_NO_DOUBLE: assert property (shift_strobe |=> !shift_strobe [*8])
        else $error("second strobe without a line going high");
    AST_PROG_OFF: assert property (
        (drive_lines == 4'h0) [*4] |-> sink_switch_on == 4'h0 && !high_side_on)
        else $error("outputs on in programming mode");
    AST_OPEN_LOOP: assert property (open_loop == $past(loop_select_data, 3))
        else $error("loop mode does not follow its line");
    AST_FULL_SINK: assert property (
        cfg_value[5] && $past(cfg_value[5], 3) &&
        $past(drive_lines[1:0] != 2'h0 && drive_lines[3:2] != 2'h0, 3)
        |-> sink_switch_on == ~$past(drive_lines, 3))
        else $error("full mapping sink pattern wrong");
    AST_FULL_REDUCE: assert property (
        cfg_value[5] && $past(cfg_value[5], 3) && $past(drive_lines, 3) != 4'h0 |->
        current_reduce_flag ==
            $past(&drive_lines[1:0] || &drive_lines[3:2] || reduce_level_data, 3))
        else $error("full mapping reduce flag wrong");
endmodule : usil_link_assertions

//--- verif/test_unipolar_stepper_input_logic.sv
// self-checking bench: APB controller programs and drives the stepper input logic
module test_unipolar_stepper_input_logic;
    timeunit 1ns;
    timeprecision 1ps;
    import usil_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sense_trip;
    logic [3:0]  sink_switch_on;
    logic        high_side_on;
    logic        current_reduce_flag;
    logic        open_loop;
    logic [9:0]  reference_mv;
    logic [6:0]  on_time_pct;
    logic [5:0]  cfg_value;
    logic        shift_strobe;
    logic [31:0] rd;
    logic        err;
    logic        hs;
    logic        hold_mode;
    logic        held_on;
    logic [1:0]  j;
    logic [9:0]  ref_exp [4];
    logic [6:0]  ont_exp [4];
    int          fail_count;
    int          samples_checked;
    int          strobes;
    int          p;

    usil_link_if link ();
    usil_ctrl i_usil_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .link(link));
    usil_device i_usil_device (.pclk, .presetn, .link(link), .sense_trip, .sink_switch_on,
        .high_side_on, .current_reduce_flag, .open_loop, .reference_mv, .on_time_pct,
        .cfg_value, .shift_strobe);
    usil_link_assertions i_usil_link_assertions (.pclk, .presetn,
        .drive_lines(link.drive_lines), .reduce_level_data(link.reduce_level_data),
        .loop_select_data(link.loop_select_data), .shift_strobe, .cfg_value,
        .sink_switch_on, .high_side_on, .open_loop, .current_reduce_flag);

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (shift_strobe === 1'b1) strobes++;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask : chk

    // one APB transfer; held until pready is seen high with penable
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // lines settle through the controller register and the device synchroniser
    task automatic drv(input logic [3:0] l, input logic r, input logic o);
        apb(1'b1, REG_DRIVE, {26'h0, o, r, l});
        repeat (6) @(posedge pclk);
    endtask : drv

    task automatic prog(input logic [5:0] c);
        int n = 0;
        strobes = 0;
        held_on = 1'b0;
        apb(1'b1, REG_CTRL,
            32'h1 | (32'(hold_mode) << CTRL_HOLD_POS) | (32'(c) << CTRL_DATA_LSB));
        // a second start while busy must be ignored
        apb(1'b1, REG_CTRL, 32'h1 | (32'(~c) << CTRL_DATA_LSB));
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
            // with the hold bit set no switch may turn on during the load
            held_on = held_on | high_side_on | (|sink_switch_on);
            n++;
        end while (rd[4] !== 1'b0 && n < 400);
        chk("busy", 32'h0, {31'h0, rd[4]});
        if (rd[4] !== 1'b0) wrap_up();
        chk("cfg", c, cfg_value);
        chk("strobes", 6, strobes);
    endtask : prog

    // cycles between two high-side turn-ons while the comparator trips at once
    task automatic period(output int q);
        int n = 0;
        int k = 0;
        logic prev = 1'b1;
        q = 0;
        while (k < 2 && n < 9000) begin
            @(posedge pclk);
            n++;
            if (k == 1) q++;
            if (high_side_on === 1'b1 && prev !== 1'b1) k++;
            prev = high_side_on;
        end
        if (k < 2) begin
            fail_count++;
            wrap_up();
        end
    endtask : period

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sense_trip = 1'b1;
        fail_count = 0;
        samples_checked = 0;
        strobes = 0;
        hold_mode = 1'b0;
        ref_exp = '{REF_40_MV, REF_70_MV, REF_55_MV, REF_85_MV};
        ont_exp = '{ONT_75, ONT_100, ONT_50, ONT_OFF};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("cfg", 6'h00, cfg_value);
        chk("outs", 5'h00, {high_side_on, sink_switch_on});
        apb(1'b0, 12'hFFC, 32'h0);
        chk("slverr", 1'b1, err);
        drv(4'hC, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            j = 2'(i);
            prog({1'b0, j[0], j, j});
            drv(4'h4, 1'b0, 1'b0);
            chk("ref", ref_exp[i], reference_mv);
            drv(4'hC, 1'b1, 1'b0);
            chk("ref", ref_exp[i], reference_mv);
            drv(4'hC, 1'b0, 1'b0);
            chk("ref", REF_NOM_MV, reference_mv);
            period(p);
            chk("chop", OSC_CYC << j[0], p);
            drv(4'hC, 1'b0, 1'b1);
            chk("ont", ont_exp[i], on_time_pct);
            chk("open", 1'b1, open_loop);
        end
        drv(4'hC, 1'b0, 1'b0);
        sense_trip <= 1'b0;
        repeat (4100) @(posedge pclk);
        chk("held high", 1'b1, high_side_on);
        sense_trip <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("tripped", 1'b0, high_side_on);
        hold_mode = 1'b1;
        prog(6'h20);
        hold_mode = 1'b0;
        chk("held off", 1'b0, held_on);
        drv(4'h5, 1'b0, 1'b0);
        chk("sinks", 4'hA, sink_switch_on);
        chk("reduce", 1'b0, current_reduce_flag);
        drv(4'h7, 1'b0, 1'b0);
        chk("reduce", 1'b1, current_reduce_flag);
        drv(4'h5, 1'b1, 1'b0);
        chk("reduce", 1'b1, current_reduce_flag);
        strobes = 0;
        // an all-low glitch of a few cycles must not shift
        apb(1'b1, REG_DRIVE, 32'h10);
        apb(1'b1, REG_DRIVE, 32'h15);
        repeat (20) @(posedge pclk);
        chk("strobes", 0, strobes);
        chk("cfg", 6'h20, cfg_value);
        drv(4'hC, 1'b0, 1'b1);
        hs = 1'b0;
        repeat (2100) begin
            @(posedge pclk);
            hs = hs | high_side_on;
        end
        chk("high", 1'b0, hs);
        strobes = 0;
        drv(4'h0, 1'b1, 1'b0);
        repeat (40) @(posedge pclk);
        chk("outs", 5'h00, {high_side_on, sink_switch_on});
        chk("strobes", 1, strobes);
        chk("cfg", 6'h01, cfg_value);
        drv(4'hC, 1'b0, 1'b0);
        chk("sinks", 4'h5, sink_switch_on);
        // a second reset in mid-run must clear the loaded bits and the switches
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("cfg", 6'h00, cfg_value);
        chk("outs", 5'h00, {high_side_on, sink_switch_on});
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("cfg", 6'h00, cfg_value);
        wrap_up();
    end
endmodule : test_unipolar_stepper_input_logic
